// ==== rtl/t16_cmp.sv ====
`timescale 1ns/1ps
module t16_cmp #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // timer side
  input wire logic tick,
  input wire logic block,
  input wire logic [CW-1:0] count,
  input wire logic [CW-1:0] compare,
  // result
  output logic match
);
  // equality is sampled on a tick, so the flag is a one-cycle pulse in the clock after the tick
  wire equal = (count == compare);
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      match <= 1'b0;
    else if (tick)
      match <= equal && !block;
    else
      match <= 1'b0;
  end
endmodule

// ==== rtl/t16_regs.sv ====
`timescale 1ns/1ps
module t16_regs #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // processor i/o register port
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // counting engine
  input wire logic tick,
  input wire logic [CW-1:0] count_next,
  input wire logic ovf_event,
  input wire logic top_event,
  input wire logic mode_ovf_event,
  input wire logic [3:0] waveform_mode_sel,
  input wire logic force_compare_a,
  input wire logic force_compare_b,
  // capture sources
  input wire logic capture_pin,
  input wire logic acomp_out,
  input wire logic capture_from_acomp,
  input wire logic capture_rising,
  // interrupt controller
  input wire logic gie,
  input wire logic vec_ack_ovf,
  input wire logic vec_ack_cmp_a,
  input wire logic vec_ack_cmp_b,
  input wire logic vec_ack_cap,
  // results
  output logic [CW-1:0] counter_value,
  output logic compare_out_a,
  output logic compare_out_b,
  output logic irq_ovf,
  output logic irq_cmp_a,
  output logic irq_cmp_b,
  output logic irq_capture
);

  // the byte map and the field positions only serve a 16-bit counter
  if (CW != 16)
  begin : g_cw_check
    $error("t16_regs: only a 16-bit counter is served by the byte map");
  end
  if (t16_pkg::IRQ_BITS_USED != ((8'h01 << t16_pkg::BIT_OVF) | (8'h01 << t16_pkg::BIT_CMPA) |
    (8'h01 << t16_pkg::BIT_CMPB) | (8'h01 << t16_pkg::BIT_CAP)))
  begin : g_bits_check
    $error("t16_regs: used-bit mask disagrees with the flag positions");
  end
  if (t16_pkg::ADDR_W != 4)
  begin : g_addr_check
    $error("t16_regs: register index must be four bits wide");
  end

  logic [7:0] temp_high;
  logic [CW-1:0] compare_value_a;
  logic [CW-1:0] compare_value_b;
  logic [CW-1:0] capture_value;
  logic [7:0] timer_irq_mask;
  logic [7:0] timer_irq_flags;
  logic block_pending;
  logic cap_src_prev;
  logic cap_primed;
  logic match_a;
  logic match_b;

  // address decode
  wire sel_cnt_l = (io_addr == t16_pkg::ADDR_CNT_L);
  wire sel_cnt_h = (io_addr == t16_pkg::ADDR_CNT_H);
  wire sel_cmpa_l = (io_addr == t16_pkg::ADDR_CMPA_L);
  wire sel_cmpa_h = (io_addr == t16_pkg::ADDR_CMPA_H);
  wire sel_cmpb_l = (io_addr == t16_pkg::ADDR_CMPB_L);
  wire sel_cmpb_h = (io_addr == t16_pkg::ADDR_CMPB_H);
  wire sel_cap_l = (io_addr == t16_pkg::ADDR_CAP_L);
  wire sel_cap_h = (io_addr == t16_pkg::ADDR_CAP_H);
  wire sel_mask = (io_addr == t16_pkg::ADDR_MASK);
  wire sel_flags = (io_addr == t16_pkg::ADDR_FLAGS);

  // high-byte writes only load the latch; low-byte writes commit
  wire wr_high = io_wr && (sel_cnt_h || sel_cmpa_h || sel_cmpb_h || sel_cap_h);
  wire wr_cnt = io_wr && sel_cnt_l;
  wire wr_cmpa = io_wr && sel_cmpa_l;
  wire wr_cmpb = io_wr && sel_cmpb_l;
  wire wr_cap = io_wr && sel_cap_l;
  wire wr_mask = io_wr && sel_mask;
  wire wr_flags = io_wr && sel_flags;
  wire rd_cnt_l = io_rd && sel_cnt_l;
  wire rd_cap_l = io_rd && sel_cap_l;
  wire [CW-1:0] write_word = {temp_high, io_wdata};

  // capture register doubles as top in these modes
  wire cap_is_top =
    (waveform_mode_sel == t16_pkg::MODE_PFC_CAP) ||
    (waveform_mode_sel == t16_pkg::MODE_PC_CAP) ||
    (waveform_mode_sel == t16_pkg::MODE_CLEAR_CAP) ||
    (waveform_mode_sel == t16_pkg::MODE_FAST_CAP);

  // capture source and edge detect
  wire cap_src = capture_from_acomp ? acomp_out : capture_pin;
  wire cap_rise = cap_src && !cap_src_prev;
  wire cap_fall = !cap_src && cap_src_prev;
  // no edge is trusted until the history holds a real sample of the source
  wire cap_edge = cap_primed && (capture_rising ? cap_rise : cap_fall);
  // the pin is cut off, not only the flag, so capture_value keeps its top value
  wire capture_event = cap_edge && !cap_is_top;

  // software write of capture register wins over a capture in the same cycle
  wire capture_load = capture_event && !wr_cap;

  // overflow source depends on waveform mode
  wire simple_mode =
    (waveform_mode_sel == t16_pkg::MODE_NORMAL) ||
    (waveform_mode_sel == t16_pkg::MODE_CLEAR_CMPA);
  wire ovf_set = simple_mode ? ovf_event : mode_ovf_event;

  // flag set and clear vectors
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[t16_pkg::BIT_OVF] = ovf_set;
    flag_set[t16_pkg::BIT_CMPA] = match_a;
    flag_set[t16_pkg::BIT_CMPB] = match_b;
    flag_set[t16_pkg::BIT_CAP] = cap_is_top ? top_event : capture_event;
    flag_clr = wr_flags ? io_wdata : 8'h00;
    flag_clr[t16_pkg::BIT_OVF] = flag_clr[t16_pkg::BIT_OVF] | vec_ack_ovf;
    flag_clr[t16_pkg::BIT_CMPA] = flag_clr[t16_pkg::BIT_CMPA] | vec_ack_cmp_a;
    flag_clr[t16_pkg::BIT_CMPB] = flag_clr[t16_pkg::BIT_CMPB] | vec_ack_cmp_b;
    flag_clr[t16_pkg::BIT_CAP] = flag_clr[t16_pkg::BIT_CAP] | vec_ack_cap;
  end

  // set wins over clear so no event is lost
  wire [7:0] next_flags =
    ((timer_irq_flags & ~flag_clr) | flag_set) & t16_pkg::IRQ_BITS_USED;
  wire [7:0] next_mask = io_wdata & t16_pkg::IRQ_BITS_USED;

  // request levels
  wire [7:0] pending = timer_irq_flags & timer_irq_mask & {8{gie}};

  // read mux; high bytes of counter and capture come from the latch
  logic [7:0] read_mux;
  always_comb
  begin
    if (sel_cnt_l)
      read_mux = counter_value[7:0];
    else if (sel_cnt_h)
      read_mux = temp_high;
    else if (sel_cmpa_l)
      read_mux = compare_value_a[7:0];
    else if (sel_cmpa_h)
      read_mux = compare_value_a[15:8];
    else if (sel_cmpb_l)
      read_mux = compare_value_b[7:0];
    else if (sel_cmpb_h)
      read_mux = compare_value_b[15:8];
    else if (sel_cap_l)
      read_mux = capture_value[7:0];
    else if (sel_cap_h)
      read_mux = temp_high;
    else if (sel_mask)
      read_mux = timer_irq_mask;
    else if (sel_flags)
      read_mux = timer_irq_flags;
    else
      read_mux = 8'h00;
  end

  // shared high-byte latch
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      temp_high <= 8'h00;
    else if (wr_high)
      temp_high <= io_wdata;
    else if (rd_cnt_l)
      temp_high <= counter_value[15:8];
    else if (rd_cap_l)
      temp_high <= capture_value[15:8];
  end

  // counter: software write wins over the engine step
  // a step that falls on the write cycle is lost, which software accepts by writing
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      counter_value <= t16_pkg::WORD_RESET;
    else if (wr_cnt)
      counter_value <= write_word;
    else if (tick)
      counter_value <= count_next;
  end

  // match block held until the next timer tick
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      block_pending <= 1'b0;
    else if (wr_cnt)
      block_pending <= 1'b1;
    else if (tick)
      block_pending <= 1'b0;
  end

  // compare registers, both bytes in one cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      compare_value_a <= t16_pkg::WORD_RESET;
    else if (wr_cmpa)
      compare_value_a <= write_word;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      compare_value_b <= t16_pkg::WORD_RESET;
    else if (wr_cmpb)
      compare_value_b <= write_word;
  end

  // capture register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      capture_value <= t16_pkg::WORD_RESET;
    else if (wr_cap)
      capture_value <= write_word;
    else if (capture_load)
      capture_value <= counter_value;
  end

  // edge detector history; inputs are already synchronous
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cap_src_prev <= 1'b0;
    else
      cap_src_prev <= cap_src;
  end

  // history is only valid one cycle after reset, whatever the idle level of the pin
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cap_primed <= 1'b0;
    else
      cap_primed <= 1'b1;
  end

  // mask and flags
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      timer_irq_mask <= t16_pkg::MASK_RESET;
    else if (wr_mask)
      timer_irq_mask <= next_mask;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      timer_irq_flags <= t16_pkg::FLAGS_RESET;
    else
      timer_irq_flags <= next_flags;
  end

  // read data holds the last read value
  // reads clear nothing here, but a stray counter or capture low-byte read reloads the shared latch
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      io_rdata <= 8'h00;
    else if (io_rd)
      io_rdata <= read_mux;
  end

  // interrupt requests, registered
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_ovf <= 1'b0;
      irq_cmp_a <= 1'b0;
      irq_cmp_b <= 1'b0;
      irq_capture <= 1'b0;
    end
    else
    begin
      irq_ovf <= pending[t16_pkg::BIT_OVF];
      irq_cmp_a <= pending[t16_pkg::BIT_CMPA];
      irq_cmp_b <= pending[t16_pkg::BIT_CMPB];
      irq_capture <= pending[t16_pkg::BIT_CAP];
    end
  end

  // compare-output strobes to the waveform unit; forced strobes go here only
  wire strobe_a = match_a || force_compare_a;
  wire strobe_b = match_b || force_compare_b;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
    end
    else
    begin
      compare_out_a <= strobe_a;
      compare_out_b <= strobe_b;
    end
  end

  // comparators
  t16_cmp #(
    .CW(CW)
  ) u_cmp_a (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick),
    .block(block_pending),
    .count(counter_value),
    .compare(compare_value_a),
    .match(match_a)
  );

  t16_cmp #(
    .CW(CW)
  ) u_cmp_b (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick),
    .block(block_pending),
    .count(counter_value),
    .compare(compare_value_b),
    .match(match_b)
  );

endmodule

// ==== shared/t16_pkg.sv ====
package t16_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CNT_L = 4'h0;
  localparam logic [3:0] ADDR_CNT_H = 4'h1;
  localparam logic [3:0] ADDR_CMPA_L = 4'h2;
  localparam logic [3:0] ADDR_CMPA_H = 4'h3;
  localparam logic [3:0] ADDR_CMPB_L = 4'h4;
  localparam logic [3:0] ADDR_CMPB_H = 4'h5;
  localparam logic [3:0] ADDR_CAP_L = 4'h6;
  localparam logic [3:0] ADDR_CAP_H = 4'h7;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  localparam logic [3:0] ADDR_FLAGS = 4'h9;
  localparam int BIT_OVF = 0;
  localparam int BIT_CMPA = 1;
  localparam int BIT_CMPB = 2;
  localparam int BIT_CAP = 5;
  localparam logic [7:0] IRQ_BITS_USED = 8'h27;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CLEAR_CMPA = 4'h4;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PC_CAP = 4'ha;
  localparam logic [3:0] MODE_CLEAR_CAP = 4'hc;
  localparam logic [3:0] MODE_FAST_CAP = 4'he;
endpackage

// ==== verification/t16_monitor.sv ====
`timescale 1ns/1ps
module t16_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // timer side
  input wire logic tick,
  input wire logic force_compare_a,
  input wire logic force_compare_b,
  input wire logic gie,
  input wire logic vec_ack_cmp_a,
  // results
  input wire logic [15:0] counter_value,
  input wire logic compare_out_a,
  input wire logic compare_out_b,
  input wire logic irq_ovf,
  input wire logic irq_cmp_a,
  input wire logic irq_cmp_b,
  input wire logic irq_capture
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  wire logic cnt_wr = io_wr && io_addr == t16_pkg::ADDR_CNT_L;
  wire logic irq_rd = io_rd && (io_addr == t16_pkg::ADDR_MASK || io_addr == t16_pkg::ADDR_FLAGS);
  // a write followed at once by a tick is the case where blocking matters
  sequence wr_then_tick_s;
    cnt_wr ##1 tick;
  endsequence
  cnt_low_write_a:
    assert property (cnt_wr |=> counter_value[7:0] == $past(io_wdata)) else $error("counter low byte lost");
  block_match_a_a:
    assert property (wr_then_tick_s ##1 !force_compare_a |=> !compare_out_a) else $error("match a not blocked");
  block_match_b_a:
    assert property (wr_then_tick_s ##1 !force_compare_b |=> !compare_out_b) else $error("match b not blocked");
  capture_irq_gie_a:
    assert property (irq_capture |-> $past(gie)) else $error("capture irq without global enable");
  other_irq_gie_a:
    assert property ((irq_ovf || irq_cmp_a || irq_cmp_b) |-> $past(gie)) else $error("irq without global enable");
  vector_clears_a:
    assert property (vec_ack_cmp_a ##1 !compare_out_a |=> !irq_cmp_a) else $error("vector did not clear flag");
  reserved_zero_a:
    assert property (irq_rd |=> io_rdata[7:6] == 2'b00 && io_rdata[4:3] == 2'b00) else $error("reserved bit set");
  unmapped_zero_a:
    assert property (io_rd && io_addr > 4'h9 |=> io_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind t16_regs t16_monitor u_monitor (.mclk, .resetn, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .tick,
  .force_compare_a, .force_compare_b, .gie, .vec_ack_cmp_a, .counter_value, .compare_out_a, .compare_out_b,
  .irq_ovf, .irq_cmp_a, .irq_cmp_b, .irq_capture);

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h expected %h", $time, (g), (e)); end end
module testbench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] io_addr = 4'h0;
  logic [7:0] io_wdata = 8'h00;
  logic [15:0] count_next = 16'h0000;
  logic [3:0] waveform_mode_sel = 4'h0;
  logic io_wr = 1'b0, io_rd = 1'b0, tick = 1'b0, ovf_event = 1'b0, top_event = 1'b0, mode_ovf_event = 1'b0;
  logic force_compare_a = 1'b0, force_compare_b = 1'b0, capture_pin = 1'b0, acomp_out = 1'b0;
  logic capture_from_acomp = 1'b0, capture_rising = 1'b1, gie = 1'b1, vec_ack_ovf = 1'b0;
  logic vec_ack_cmp_a = 1'b0, vec_ack_cmp_b = 1'b0, vec_ack_cap = 1'b0;
  logic [7:0] io_rdata;
  logic [15:0] counter_value;
  logic compare_out_a, compare_out_b, irq_ovf, irq_cmp_a, irq_cmp_b, irq_capture;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  t16_regs u_dut (.mclk, .resetn, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .tick, .count_next, .ovf_event,
    .top_event, .mode_ovf_event, .waveform_mode_sel, .force_compare_a, .force_compare_b, .capture_pin, .acomp_out,
    .capture_from_acomp, .capture_rising, .gie, .vec_ack_ovf, .vec_ack_cmp_a, .vec_ack_cmp_b, .vec_ack_cap,
    .counter_value, .compare_out_a, .compare_out_b, .irq_ovf, .irq_cmp_a, .irq_cmp_b, .irq_capture);
  always #4 mclk = ~mclk;
  task automatic final_report;
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // run is under two hundred cycles; the ceiling only catches a hang
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      final_report();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge mclk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    `CHK(io_rdata, e)
  endtask
  // high byte first so the shared latch is loaded before the commit
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask
  task automatic rd16(input logic [3:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a + 4'h1, e[15:8]);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
    @(negedge mclk);
  endtask
  task automatic tk(input logic [15:0] v);
    count_next = v;
    pulse(tick);
  endtask
  task automatic flg(input logic [7:0] e);
    repeat (2) @(negedge mclk);
    rd(t16_pkg::ADDR_FLAGS, e);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    rd(t16_pkg::ADDR_MASK, 8'h00);
    flg(8'h00);
    wr16(t16_pkg::ADDR_CNT_L, 16'h1234);
    rd16(t16_pkg::ADDR_CNT_L, 16'h1234);
    wr(t16_pkg::ADDR_MASK, 8'hff);
    rd(t16_pkg::ADDR_MASK, 8'h27);
    wr16(t16_pkg::ADDR_CMPA_L, 16'h0100);
    wr16(t16_pkg::ADDR_CMPB_L, 16'h0101);
    rd16(t16_pkg::ADDR_CMPA_L, 16'h0100);
    rd16(t16_pkg::ADDR_CMPB_L, 16'h0101);
    tk(16'h0100);
    tk(16'h0101);
    `CHK(compare_out_a, 1'b1)
    flg(8'h02);
    `CHK(irq_cmp_a, 1'b1)
    wr(t16_pkg::ADDR_FLAGS, 8'h00);
    flg(8'h02);
    wr(t16_pkg::ADDR_FLAGS, 8'h02);
    flg(8'h00);
    tk(16'h0102);
    `CHK(compare_out_b, 1'b1)
    flg(8'h04);
    `CHK(irq_cmp_b, 1'b1)
    pulse(vec_ack_cmp_b);
    force_compare_a = 1'b1;
    @(negedge mclk);
    force_compare_a = 1'b0;
    `CHK(compare_out_a, 1'b1)
    force_compare_b = 1'b1;
    @(negedge mclk);
    force_compare_b = 1'b0;
    `CHK(compare_out_b, 1'b1)
    flg(8'h00);
    wr16(t16_pkg::ADDR_CNT_L, 16'h0100);
    tk(16'h0100);
    flg(8'h00);
    tk(16'h0101);
    pulse(ovf_event);
    flg(8'h03);
    `CHK(irq_ovf, 1'b1)
    pulse(vec_ack_ovf);
    pulse(vec_ack_cmp_a);
    flg(8'h00);
    waveform_mode_sel = t16_pkg::MODE_CLEAR_CMPA;
    pulse(ovf_event);
    flg(8'h01);
    wr(t16_pkg::ADDR_FLAGS, 8'h01);
    waveform_mode_sel = t16_pkg::MODE_PFC_CAP;
    pulse(ovf_event);
    flg(8'h00);
    pulse(mode_ovf_event);
    flg(8'h01);
    wr(t16_pkg::ADDR_FLAGS, 8'hff);
    waveform_mode_sel = t16_pkg::MODE_CLEAR_CAP;
    capture_pin = 1'b1;
    flg(8'h00);
    capture_pin = 1'b0;
    waveform_mode_sel = t16_pkg::MODE_FAST_CAP;
    pulse(top_event);
    flg(8'h20);
    pulse(vec_ack_cap);
    waveform_mode_sel = t16_pkg::MODE_NORMAL;
    flg(8'h00);
    capture_pin = 1'b1;
    flg(8'h20);
    rd16(t16_pkg::ADDR_CAP_L, 16'h0101);
    `CHK(irq_capture, 1'b1)
    gie = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK(irq_capture, 1'b0)
    gie = 1'b1;
    pulse(vec_ack_cap);
    capture_from_acomp = 1'b1;
    @(negedge mclk);
    acomp_out = 1'b1;
    flg(8'h20);
    pulse(vec_ack_cap);
    wr16(t16_pkg::ADDR_CNT_L, 16'h5aa5);
    capture_rising = 1'b0;
    acomp_out = 1'b0;
    flg(8'h20);
    rd16(t16_pkg::ADDR_CAP_L, 16'h5aa5);
    wr(4'ha, 8'hff);
    rd(4'ha, 8'h00);
    final_report();
  end
endmodule
